// File: pcdm_pkg.sv
package pcdm_pkg;

  // ---------------------------------------------------------------
  // Register offsets in configuration space
  // ---------------------------------------------------------------
  localparam logic [11:0] PCDM_UNC_OFF = 12'h218;
  localparam logic [11:0] PCDM_COR_OFF = 12'h21C;
  localparam logic [11:0] PCDM_MSG_OFF = 12'h220;
  localparam logic [11:0] PCDM_CLU_UNC_OFF = 12'h224;
  localparam logic [11:0] PCDM_CLU_COR_OFF = 12'h228;

  // ---------------------------------------------------------------
  // Field positions, uncorrectable detect mask
  // ---------------------------------------------------------------
  localparam int PCDM_UNC_DLL_PROT = 4;
  localparam int PCDM_UNC_SURPRISE_DOWN = 5;
  localparam int PCDM_UNC_POISONED = 12;
  localparam int PCDM_UNC_FC_PROT = 13;
  localparam int PCDM_UNC_CPL_TIMEOUT = 14;
  localparam int PCDM_UNC_CPL_ABORT = 15;
  localparam int PCDM_UNC_UNEXP_CPL = 16;
  localparam int PCDM_UNC_RX_OVERFLOW = 17;
  localparam int PCDM_UNC_MALFORMED = 18;
  localparam int PCDM_UNC_UNSUP_REQ = 20;
  localparam int PCDM_UNC_ACS_VIOL = 21;

  // ---------------------------------------------------------------
  // Field positions, correctable detect mask
  // ---------------------------------------------------------------
  localparam int PCDM_COR_RX_ERR = 0;
  localparam int PCDM_COR_BAD_TLP = 6;
  localparam int PCDM_COR_BAD_DLLP = 7;
  localparam int PCDM_COR_REPLAY_ROLL = 8;
  localparam int PCDM_COR_REPLAY_TMO = 12;
  localparam int PCDM_COR_ADVISORY = 13;

  // ---------------------------------------------------------------
  // Field positions, received message detect mask
  // ---------------------------------------------------------------
  localparam int PCDM_MSG_COR = 0;
  localparam int PCDM_MSG_NONFATAL = 1;
  localparam int PCDM_MSG_FATAL = 2;
  localparam int PCDM_MSG_W = 3;

  // ---------------------------------------------------------------
  // Field positions, port cluster detect masks
  // ---------------------------------------------------------------
  localparam int PCDM_CLU_SWBUF_PARITY = 1;
  localparam int PCDM_CLU_SENT_CA = 3;
  localparam int PCDM_CLU_SENT_UR = 4;
  localparam int PCDM_CLU_RX_CA = 5;
  localparam int PCDM_CLU_RX_UR = 6;
  localparam int PCDM_CLU_MSI_BIG = 8;
  localparam int PCDM_CLU_OUT_POISON = 9;
  localparam int PCDM_CLU_BW_CHANGE = 0;

  // ---------------------------------------------------------------
  // Implemented bits; every implemented bit resets to one
  // ---------------------------------------------------------------
  localparam logic [31:0] PCDM_UNC_IMPL = 32'h0037_F030;
  localparam logic [31:0] PCDM_COR_IMPL = 32'h0000_31C1;
  localparam logic [31:0] PCDM_MSG_IMPL = 32'h0000_0007;
  localparam logic [31:0] PCDM_CLU_UNC_IMPL = 32'h0000_037A;
  localparam logic [31:0] PCDM_CLU_COR_IMPL = 32'h0000_0001;
  localparam logic [31:0] PCDM_UNC_RST = PCDM_UNC_IMPL;
  localparam logic [31:0] PCDM_COR_RST = PCDM_COR_IMPL;
  localparam logic [31:0] PCDM_MSG_RST = PCDM_MSG_IMPL;
  localparam logic [31:0] PCDM_CLU_UNC_RST = PCDM_CLU_UNC_IMPL;
  localparam logic [31:0] PCDM_CLU_COR_RST = PCDM_CLU_COR_IMPL;

  localparam logic [31:0] PCDM_ZERO = 32'h0000_0000;

  function automatic logic [31:0] pcdm_be_expand(input logic [3:0] be);
    pcdm_be_expand = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  function automatic logic pcdm_hit(input logic [11:0] addr, input logic [11:0] off);
    pcdm_hit = (addr[11:2] == off[11:2]);
  endfunction

endpackage

// File: pcdm_mask_reg.sv
`timescale 1ns/10ps
`default_nettype none
module pcdm_mask_reg
  import pcdm_pkg::*;
#(
  parameter logic [31:0] IMPL = 32'h0000_0000,
  parameter logic [31:0] RST_VAL = 32'h0000_0000
) (
  input wire logic clk_i,
  input wire logic pwrgood_rst_b_i,
  input wire logic we_i,
  input wire logic [3:0] be_i,
  input wire logic [31:0] wdata_i,
  output var logic [31:0] mask_o
);

  logic [31:0] mask_q;
  logic [31:0] mask_d;
  logic [31:0] wr_bits;

  assign wr_bits = pcdm_be_expand(be_i) & IMPL;

  always_comb begin
    mask_d = mask_q;
    if (we_i) begin
      mask_d = (mask_q & ~wr_bits) | (wdata_i & wr_bits);
    end
  end

  // ---------------------------------------------------------------
  // Sticky storage
  // ---------------------------------------------------------------
  // Only the power-good reset touches these bits, so masks chosen by
  // software survive a warm reset of the rest of the port.
  // sticky mask bits
  always_ff @(posedge clk_i or negedge pwrgood_rst_b_i) begin
    if (!pwrgood_rst_b_i) begin
      mask_q <= RST_VAL;
    end else begin
      mask_q <= mask_d;
    end
  end

  assign mask_o = mask_q & IMPL;

endmodule
`default_nettype wire

// File: pcdm_detect_masks.sv
`timescale 1ns/10ps
`default_nettype none
// Function
// - masked uncorrectable error sets no status
// - uncorrectable mask bits twelve through eighteen
// - unsupported request twenty, ACS twenty-one
// - link protocol four, surprise down five
// - masked correctable error sets no status
// - correctable bits zero, six, seven, eight
// - replay timeout twelve, advisory thirteen
// - message mask ignores internal virtual messages
// - message bits correctable, nonfatal, fatal
// - cluster poisoned nine, large MSI eight
// - cluster completion bits three to six
// - cluster parity bit one, others reserved
// - cluster correctable bandwidth change bit zero
// - all implemented mask bits reset one
module pcdm_detect_masks
  import pcdm_pkg::*;
(
  input wire logic CLK_SYS_I,
  input wire logic RST_B_I,
  input wire logic PWRGOOD_RST_B_I,
  input wire logic CFG_WR_I,
  input wire logic CFG_RD_I,
  input wire logic [11:0] CFG_ADDR_I,
  input wire logic [3:0] CFG_BE_I,
  input wire logic [31:0] CFG_WDATA_I,
  output var logic [31:0] CFG_RDATA_O,
  output var logic CFG_RACK_O,
  input wire logic [31:0] UNC_ERR_I,
  input wire logic [31:0] COR_ERR_I,
  input wire logic [2:0] LINK_MSG_ERR_I,
  input wire logic [2:0] VIRT_MSG_ERR_I,
  input wire logic [31:0] CLU_UNC_ERR_I,
  input wire logic CLU_COR_ERR_I,
  output var logic [31:0] UNC_STS_SET_O,
  output var logic [31:0] COR_STS_SET_O,
  output var logic [2:0] MSG_STS_SET_O,
  output var logic [31:0] CLU_UNC_STS_SET_O,
  output var logic CLU_COR_STS_SET_O
);

  logic [31:0] unc_mask;
  logic [31:0] cor_mask;
  logic [31:0] msg_mask;
  logic [31:0] clu_unc_mask;
  logic [31:0] clu_cor_mask;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  logic rack_q;
  logic [31:0] unc_set_q;
  logic [31:0] cor_set_q;
  logic [2:0] msg_set_q;
  logic [31:0] clu_unc_set_q;
  logic clu_cor_set_q;
  logic [31:0] unc_set_d;
  logic [31:0] cor_set_d;
  logic [2:0] msg_set_d;
  logic [31:0] clu_unc_set_d;
  logic clu_cor_set_d;

  // ---------------------------------------------------------------
  // Mask registers
  // ---------------------------------------------------------------
  // uncorrectable layout
  pcdm_mask_reg #(
    .IMPL(PCDM_UNC_IMPL),
    .RST_VAL(PCDM_UNC_RST)
  ) u_unc (
    .clk_i(CLK_SYS_I),
    .pwrgood_rst_b_i(PWRGOOD_RST_B_I),
    .we_i(CFG_WR_I && pcdm_hit(CFG_ADDR_I, PCDM_UNC_OFF)),
    .be_i(CFG_BE_I),
    .wdata_i(CFG_WDATA_I),
    .mask_o(unc_mask)
  );

  pcdm_mask_reg #(
    .IMPL(PCDM_COR_IMPL),
    .RST_VAL(PCDM_COR_RST)
  ) u_cor (
    .clk_i(CLK_SYS_I),
    .pwrgood_rst_b_i(PWRGOOD_RST_B_I),
    .we_i(CFG_WR_I && pcdm_hit(CFG_ADDR_I, PCDM_COR_OFF)),
    .be_i(CFG_BE_I),
    .wdata_i(CFG_WDATA_I),
    .mask_o(cor_mask)
  );

  pcdm_mask_reg #(
    .IMPL(PCDM_MSG_IMPL),
    .RST_VAL(PCDM_MSG_RST)
  ) u_msg (
    .clk_i(CLK_SYS_I),
    .pwrgood_rst_b_i(PWRGOOD_RST_B_I),
    .we_i(CFG_WR_I && pcdm_hit(CFG_ADDR_I, PCDM_MSG_OFF)),
    .be_i(CFG_BE_I),
    .wdata_i(CFG_WDATA_I),
    .mask_o(msg_mask)
  );

  pcdm_mask_reg #(
    .IMPL(PCDM_CLU_UNC_IMPL),
    .RST_VAL(PCDM_CLU_UNC_RST)
  ) u_clu_unc (
    .clk_i(CLK_SYS_I),
    .pwrgood_rst_b_i(PWRGOOD_RST_B_I),
    .we_i(CFG_WR_I && pcdm_hit(CFG_ADDR_I, PCDM_CLU_UNC_OFF)),
    .be_i(CFG_BE_I),
    .wdata_i(CFG_WDATA_I),
    .mask_o(clu_unc_mask)
  );

  pcdm_mask_reg #(
    .IMPL(PCDM_CLU_COR_IMPL),
    .RST_VAL(PCDM_CLU_COR_RST)
  ) u_clu_cor (
    .clk_i(CLK_SYS_I),
    .pwrgood_rst_b_i(PWRGOOD_RST_B_I),
    .we_i(CFG_WR_I && pcdm_hit(CFG_ADDR_I, PCDM_CLU_COR_OFF)),
    .be_i(CFG_BE_I),
    .wdata_i(CFG_WDATA_I),
    .mask_o(clu_cor_mask)
  );

  // ---------------------------------------------------------------
  // Configuration read path
  // ---------------------------------------------------------------
  // Unmapped offsets read as zero so software probing the space
  // never sees stale data.
  always_comb begin
    rdata_d = PCDM_ZERO;
    if (pcdm_hit(CFG_ADDR_I, PCDM_UNC_OFF)) begin
      rdata_d = unc_mask;
    end else if (pcdm_hit(CFG_ADDR_I, PCDM_COR_OFF)) begin
      rdata_d = cor_mask;
    end else if (pcdm_hit(CFG_ADDR_I, PCDM_MSG_OFF)) begin
      rdata_d = msg_mask;
    end else if (pcdm_hit(CFG_ADDR_I, PCDM_CLU_UNC_OFF)) begin
      rdata_d = clu_unc_mask;
    end else if (pcdm_hit(CFG_ADDR_I, PCDM_CLU_COR_OFF)) begin
      rdata_d = clu_cor_mask;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rdata_q <= PCDM_ZERO;
    end else if (CFG_RD_I) begin
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rack_q <= 1'b0;
    end else begin
      rack_q <= CFG_RD_I;
    end
  end

  // ---------------------------------------------------------------
  // Detection gating
  // ---------------------------------------------------------------
  // The gated events are registered so every output is a flop; this
  // costs one cycle of latency toward the status logic.
  // gate uncorrectable errors
  assign unc_set_d = UNC_ERR_I & PCDM_UNC_IMPL & ~unc_mask;
  assign cor_set_d = COR_ERR_I & PCDM_COR_IMPL & ~cor_mask;
  assign msg_set_d = (LINK_MSG_ERR_I & ~msg_mask[PCDM_MSG_W-1:0]) | VIRT_MSG_ERR_I;
  assign clu_unc_set_d = CLU_UNC_ERR_I & PCDM_CLU_UNC_IMPL & ~clu_unc_mask;
  assign clu_cor_set_d = CLU_COR_ERR_I & ~clu_cor_mask[PCDM_CLU_BW_CHANGE];

  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      unc_set_q <= PCDM_ZERO;
    end else begin
      unc_set_q <= unc_set_d;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      cor_set_q <= PCDM_ZERO;
    end else begin
      cor_set_q <= cor_set_d;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      msg_set_q <= 3'h0;
    end else begin
      msg_set_q <= msg_set_d;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      clu_unc_set_q <= PCDM_ZERO;
    end else begin
      clu_unc_set_q <= clu_unc_set_d;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      clu_cor_set_q <= 1'b0;
    end else begin
      clu_cor_set_q <= clu_cor_set_d;
    end
  end

  assign CFG_RDATA_O = rdata_q;
  assign CFG_RACK_O = rack_q;
  assign UNC_STS_SET_O = unc_set_q;
  assign COR_STS_SET_O = cor_set_q;
  assign MSG_STS_SET_O = msg_set_q;
  assign CLU_UNC_STS_SET_O = clu_unc_set_q;
  assign CLU_COR_STS_SET_O = clu_cor_set_q;

endmodule
`default_nettype wire

// File: pcdm_detect_masks_chk.sv
`timescale 1ns/10ps
`default_nettype none
// ----
// Checker
// ----
module pcdm_detect_masks_chk
  import pcdm_pkg::*;
(
  input wire logic CLK_SYS_I,
  input wire logic RST_B_I,
  input wire logic CFG_RD_I,
  input wire logic [11:0] CFG_ADDR_I,
  input wire logic [31:0] CFG_RDATA_O,
  input wire logic CFG_RACK_O,
  input wire logic [31:0] UNC_ERR_I,
  input wire logic [31:0] COR_ERR_I,
  input wire logic [2:0] LINK_MSG_ERR_I,
  input wire logic [2:0] VIRT_MSG_ERR_I,
  input wire logic CLU_COR_ERR_I,
  input wire logic [31:0] UNC_STS_SET_O,
  input wire logic [31:0] COR_STS_SET_O,
  input wire logic [2:0] MSG_STS_SET_O,
  input wire logic [31:0] CLU_UNC_STS_SET_O,
  input wire logic CLU_COR_STS_SET_O
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_B_I);
  property p_msg_rd;
    CFG_RD_I && CFG_ADDR_I[11:2] == PCDM_MSG_OFF[11:2] |=> CFG_RACK_O && CFG_RDATA_O[31:3] == 29'h0;
  endproperty
  a_msg_rd: assert property (p_msg_rd) else $error("message mask reserved bits set");
  property p_cor_rd;
    CFG_RD_I && CFG_ADDR_I[11:2] == PCDM_COR_OFF[11:2] |=> (CFG_RDATA_O & ~PCDM_COR_IMPL) == 32'h0;
  endproperty
  a_cor_rd: assert property (p_cor_rd) else $error("correctable mask reserved bits set");
  property p_unc_gate;
    1'b1 |=> (UNC_STS_SET_O & ~$past(UNC_ERR_I)) == 32'h0;
  endproperty
  a_unc_gate: assert property (p_unc_gate) else $error("uncorrectable status without error");
  property p_unc_rsvd;
    (UNC_STS_SET_O & ~PCDM_UNC_IMPL) == 32'h0;
  endproperty
  a_unc_rsvd: assert property (p_unc_rsvd) else $error("reserved uncorrectable status set");
  property p_cor_gate;
    |COR_STS_SET_O |-> (COR_STS_SET_O & ~($past(COR_ERR_I) & PCDM_COR_IMPL)) == 32'h0;
  endproperty
  a_cor_gate: assert property (p_cor_gate) else $error("correctable status out of place");
  property p_virt;
    |VIRT_MSG_ERR_I |=> (MSG_STS_SET_O & $past(VIRT_MSG_ERR_I)) == $past(VIRT_MSG_ERR_I);
  endproperty
  a_virt: assert property (p_virt) else $error("virtual message was suppressed");
  property p_msg_src;
    |MSG_STS_SET_O |-> (MSG_STS_SET_O & ~($past(LINK_MSG_ERR_I) | $past(VIRT_MSG_ERR_I))) == 3'h0;
  endproperty
  a_msg_src: assert property (p_msg_src) else $error("message status without message");
  property p_clu_rsvd;
    (CLU_UNC_STS_SET_O & ~PCDM_CLU_UNC_IMPL) == 32'h0;
  endproperty
  a_clu_rsvd: assert property (p_clu_rsvd) else $error("reserved cluster status set");
  property p_bw;
    CLU_COR_STS_SET_O |-> $past(CLU_COR_ERR_I);
  endproperty
  a_bw: assert property (p_bw) else $error("bandwidth status without event");
  c_rd: cover property (CFG_RACK_O);
  c_unc: cover property (|UNC_STS_SET_O);
  c_msg: cover property (|MSG_STS_SET_O);
endmodule
bind pcdm_detect_masks pcdm_detect_masks_chk u_chk (.*);
`default_nettype wire

// File: pcdm_link_partner.sv
`timescale 1ns/10ps
`default_nettype none
// ----
// Link partner
// ----
module pcdm_link_partner (
  input wire logic send_i,
  input wire logic [2:0] kind_i,
  output var logic [2:0] msg_o
);
  // Messages are one-cycle events, so an idle line means no message.
  assign msg_o = send_i ? kind_i : 3'h0;
endmodule
`default_nettype wire

// File: test_pcdm_detect_masks.sv
`timescale 1ns/10ps
`default_nettype none
// ----
// Testbench
// ----
module test_pcdm_detect_masks
  import pcdm_pkg::*;
;
  typedef struct {int due; logic [31:0] u, c, k; logic [2:0] g; logic b;} pcdm_exp_t;
  logic clk, rst_b, pg_b, wr, rd, send, bw, rack, so_bw;
  logic [11:0] addr;
  logic [3:0] be;
  logic [31:0] wd, unc, cor, cun, rdata, so_unc, so_cor, so_cun;
  logic [2:0] virt, kind, link, so_msg;
  logic [11:0] offs [6];
  logic [31:0] impl [6];
  logic [31:0] m [6];
  logic [31:0] rd_q [$];
  pcdm_exp_t exp_q [$];
  pcdm_exp_t ex;
  int error_cnt, samples_checked, cyc, i;
  pcdm_link_partner u_lp (.send_i(send), .kind_i(kind), .msg_o(link));
  pcdm_detect_masks uut (.CLK_SYS_I(clk), .RST_B_I(rst_b), .PWRGOOD_RST_B_I(pg_b),
    .CFG_WR_I(wr), .CFG_RD_I(rd), .CFG_ADDR_I(addr), .CFG_BE_I(be), .CFG_WDATA_I(wd),
    .CFG_RDATA_O(rdata), .CFG_RACK_O(rack), .UNC_ERR_I(unc), .COR_ERR_I(cor),
    .LINK_MSG_ERR_I(link), .VIRT_MSG_ERR_I(virt), .CLU_UNC_ERR_I(cun), .CLU_COR_ERR_I(bw),
    .UNC_STS_SET_O(so_unc), .COR_STS_SET_O(so_cor), .MSG_STS_SET_O(so_msg),
    .CLU_UNC_STS_SET_O(so_cun), .CLU_COR_STS_SET_O(so_bw));
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic chk_sts(string n, logic [31:0] e, logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  // Index five is an unmapped address, so its model stays zero.
  task automatic wr_reg(int r, logic [3:0] b, logic [31:0] d);
    logic [31:0] bm;
    bm = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
    wr = 1;
    addr = offs[r];
    be = b;
    wd = d;
    tick;
    wr = 0;
    m[r] = (m[r] & ~bm) | (d & bm & impl[r]);
    tick;
  endtask
  task automatic rd_reg(int r);
    rd = 1;
    addr = offs[r];
    rd_q.push_back(m[r]);
    tick;
    rd = 0;
    tick;
  endtask
  // A quiet cycle follows each burst so a reset or a new burst never
  // lands before the result of this one has been compared.
  task automatic err(logic [31:0] u, c, k, logic [2:0] l, v, logic b);
    pcdm_exp_t e;
    e.due = cyc + 1;
    e.u = u & impl[0] & ~m[0];
    e.c = c & impl[1] & ~m[1];
    e.k = k & impl[3] & ~m[3];
    e.g = (l & ~m[2][2:0]) | v;
    e.b = b & ~m[4][0];
    unc = u;
    cor = c;
    cun = k;
    send = 1;
    kind = l;
    virt = v;
    bw = b;
    exp_q.push_back(e);
    tick;
    {unc, cor, cun, send, virt, bw} = '0;
    tick;
  endtask
  always @(negedge clk) begin
    if (rack === 1'b1) begin
      if (rd_q.size() == 0) chk("rack", 32'h0, 32'h1);
      else chk("rdata", rd_q.pop_front(), rdata);
    end
    if (exp_q.size() > 0 && exp_q[0].due == cyc) begin
      ex = exp_q.pop_front();
      chk_sts("unc", ex.u, so_unc);
      chk_sts("cor", ex.c, so_cor);
      chk_sts("msg", 32'(ex.g), 32'(so_msg));
      chk_sts("clu", ex.k, so_cun);
      chk_sts("bw", 32'(ex.b), 32'(so_bw));
    end
  end
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    tally_and_finish;
  end
  initial begin
    void'($urandom(32'h6683D766));
    {rst_b, pg_b, wr, rd, send, bw, addr, be, wd, unc, cor, cun, virt, kind} = '0;
    offs = '{PCDM_UNC_OFF, PCDM_COR_OFF, PCDM_MSG_OFF, PCDM_CLU_UNC_OFF, PCDM_CLU_COR_OFF, 12'h22C};
    impl = '{PCDM_UNC_IMPL, PCDM_COR_IMPL, PCDM_MSG_IMPL, PCDM_CLU_UNC_IMPL, PCDM_CLU_COR_IMPL,
      32'h0};
    m = impl;
    repeat (3) @(posedge clk);
    #1;
    rst_b = 1;
    pg_b = 1;
    tick;
    for (i = 0; i < 6; i++) rd_reg(i);
    err('1, '1, '1, 3'h7, 3'h0, 1'b1);
    err(32'h0, 32'h0, 32'h0, 3'h7, 3'h5, 1'b0);
    for (i = 0; i < 6; i++) begin
      wr_reg(i, 4'hF, '1);
      rd_reg(i);
      err('1, '1, '1, 3'h7, 3'h2, 1'b1);
      wr_reg(i, 4'hF, 32'h0);
      rd_reg(i);
    end
    err('1, '1, '1, 3'h7, 3'h0, 1'b1);
    repeat (60) begin
      wr_reg($urandom_range(5), 4'($urandom), $urandom);
      err($urandom, $urandom, $urandom, 3'($urandom), 3'($urandom), 1'($urandom));
    end
    // An ordinary reset must leave the sticky masks alone.
    rst_b = 0;
    tick;
    rst_b = 1;
    tick;
    for (i = 0; i < 6; i++) rd_reg(i);
    pg_b = 0;
    tick;
    pg_b = 1;
    tick;
    m = impl;
    for (i = 0; i < 6; i++) rd_reg(i);
    repeat (3) tick;
    if (rd_q.size() != 0 || exp_q.size() != 0) chk("drain", 32'h0, 32'h1);
    tally_and_finish;
  end
endmodule
`default_nettype wire
